// File: wpo_pkg.sv
// Shared constants, command codes and decode types for the write posting order block
package wpo_pkg;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_NEAR_FULL = 8'hFD;
    localparam int FLAG_W = 5;
    localparam int FL_WR_DONE = 0;
    localparam int FL_NP_SEL = 1;
    localparam int FL_POST_SYNC = 2;
    localparam int FL_STALL = 3;
    localparam int FL_NOTIFY = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_POSTED_CNT = 4'h8;
    localparam logic [3:0] OFF_NP_CNT = 4'hC;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_FORCE_NP = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int ST_BUSY = 0;
    localparam int ST_STALLED = 1;
    localparam int ST_CNT_LSB = 8;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_REG_TO_MEM = 4'h1,
        OP_MEM_COPY = 4'h2,
        OP_IDX_STORE = 4'h3,
        OP_IMM_STORE = 4'h4,
        OP_HEAD_REPORT = 4'h5,
        OP_TT_UPDATE = 4'h6,
        OP_PERF_REPORT = 4'h7,
        OP_ATOMIC = 4'h8,
        OP_DW_FLUSH = 4'h9,
        OP_DW_FLUSH_ALT = 4'hA,
        OP_PIPE_SYNC = 4'hB,
        OP_USER_INT = 4'hC
    } wpo_op_e;
    typedef struct packed {
        logic wr;
        logic np;
        logic flush;
    } wpo_dec_s;
endpackage

// File: wpo_cnt_if.sv
// Carrier between the ordering engine and its outstanding posted write counter
`timescale 1ns/1ps
`default_nettype none
interface wpo_cnt_if;
    logic inc;
    logic dec;
    logic [wpo_pkg::CNT_W-1:0] count;
    logic zero;
    logic near_full;
    modport ctl (output inc, output dec, input count, input zero, input near_full);
    modport cnt (input inc, input dec, output count, output zero, output near_full);
endinterface
`default_nettype wire

// File: wpo_post_counter.sv
// Outstanding posted write counter
`timescale 1ns/1ps
`default_nettype none
module wpo_post_counter (
    input wire logic i_clock,
    input wire logic i_reset,
    wpo_cnt_if.cnt cif
);
    logic [wpo_pkg::CNT_W-1:0] count_reg;

    // Issue and acknowledge in one cycle cancel out
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            count_reg <= '0;
        end else if (cif.inc && !cif.dec) begin
            count_reg <= count_reg + 8'h01;
        end else if (cif.dec && !cif.inc && count_reg != '0) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    assign cif.count = count_reg;
    assign cif.zero = (count_reg == '0);
    assign cif.near_full = (count_reg >= wpo_pkg::CNT_NEAR_FULL);

    chk_count_up: assert property (@(posedge i_clock) disable iff (i_reset)
        (cif.inc && !cif.dec) |=> (count_reg == $past(count_reg) + 8'h01))
        else $error("posted counter missed an issue");
    chk_count_down: assert property (@(posedge i_clock) disable iff (i_reset)
        (cif.dec && !cif.inc && count_reg != '0) |=> (count_reg == $past(count_reg) - 8'h01))
        else $error("posted counter missed an acknowledge");
endmodule // wpo_post_counter
`default_nettype wire

// File: wpo_posting_order.sv
// Write posting order engine: posted and non-posted command writes, flush points, register slave
// How it works
// - Posted write: issue it and take the next command without waiting.
// - Non-posted write: stall command intake until the write is globally observed.
// - Non-posted completion also waits until all earlier posted writes are observed.
// - Every posted write is tracked until its acknowledge arrives.
// - A read after a posted write may see stale data; no protection given.
// - Register store, copy, indexed store, head, table update, perf report: posted unless force non-posted is set.
// - Immediate store is non-posted with write completion option, posted otherwise.
// - Per-command posted or non-posted selection, atomic included, is honoured.
// - Dword flush with post-sync writes non-posted.
// - Pipe sync post-sync writes posted if non-stalling, non-posted if stalling.
// - Stalling pipe sync, dword flush, user interrupt, notify: drain posted writes.
`timescale 1ns/1ps
`default_nettype none
module wpo_posting_order (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_cmd_valid,
    input wire logic [3:0] i_cmd_op,
    input wire logic [wpo_pkg::FLAG_W-1:0] i_cmd_flags,
    input wire logic [31:0] i_cmd_addr,
    input wire logic [31:0] i_cmd_data,
    output logic o_cmd_ready,
    output logic o_wr_valid,
    output logic o_wr_posted,
    output logic [31:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    input wire logic i_wr_ready,
    input wire logic i_go_valid,
    input wire logic i_go_posted,
    output logic o_stalled,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_NP_WAIT,
        ST_DRAIN
    } wpo_state_e;

    wpo_state_e state_reg;
    wpo_state_e state_next;
    logic [1:0] ctrl_reg;
    logic pend_np_reg;
    logic pend_flush_reg;
    logic [15:0] posted_cnt_reg;
    logic [15:0] np_cnt_reg;
    logic cmd_take;
    logic wr_take;
    logic np_done;
    logic ready_next;
    wpo_pkg::wpo_dec_s dec;

    wpo_cnt_if cif ();

    wpo_post_counter u_counter (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .cif(cif)
    );

    function automatic wpo_pkg::wpo_dec_s decode(
        input logic [3:0] op,
        input logic [wpo_pkg::FLAG_W-1:0] fl,
        input logic force_np
    );
        wpo_pkg::wpo_dec_s d;
        d = '0;
        case (op)
            wpo_pkg::OP_REG_TO_MEM, wpo_pkg::OP_MEM_COPY, wpo_pkg::OP_IDX_STORE,
            wpo_pkg::OP_HEAD_REPORT, wpo_pkg::OP_TT_UPDATE, wpo_pkg::OP_PERF_REPORT: begin
                d.wr = 1'b1;
            end
            wpo_pkg::OP_IMM_STORE: begin
                d.wr = 1'b1;
                d.np = fl[wpo_pkg::FL_WR_DONE];
            end
            wpo_pkg::OP_ATOMIC: begin
                d.wr = 1'b1;
                d.np = fl[wpo_pkg::FL_NP_SEL];
            end
            wpo_pkg::OP_DW_FLUSH, wpo_pkg::OP_DW_FLUSH_ALT: begin
                d.wr = fl[wpo_pkg::FL_POST_SYNC];
                d.np = 1'b1;
                d.flush = 1'b1;
            end
            wpo_pkg::OP_PIPE_SYNC: begin
                d.wr = fl[wpo_pkg::FL_POST_SYNC];
                d.np = fl[wpo_pkg::FL_STALL];
                d.flush = fl[wpo_pkg::FL_STALL] | fl[wpo_pkg::FL_NOTIFY];
            end
            wpo_pkg::OP_USER_INT: begin
                d.flush = 1'b1;
            end
            default: begin
                d = '0;
            end
        endcase
        // Software override makes every write a flush point, at a latency cost
        if (force_np && d.wr) begin
            d.np = 1'b1;
        end
        return d;
    endfunction

    assign cmd_take = i_cmd_valid && o_cmd_ready;
    assign wr_take = o_wr_valid && i_wr_ready;
    assign np_done = i_go_valid && !i_go_posted;
    assign dec = decode(i_cmd_op, i_cmd_flags, ctrl_reg[wpo_pkg::CTRL_FORCE_NP]);

    // Reads are not ordered against posted writes here; that hazard is left to software
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_take && dec.wr) begin
                    state_next = ST_ISSUE;
                end else if (cmd_take && dec.flush) begin
                    state_next = ST_DRAIN;
                end
            end
            ST_ISSUE: begin
                if (wr_take && pend_np_reg) begin
                    state_next = ST_NP_WAIT;
                end else if (wr_take && pend_flush_reg) begin
                    state_next = ST_DRAIN;
                end else if (wr_take) begin
                    state_next = ST_IDLE;
                end
            end
            ST_NP_WAIT: begin
                if (np_done) begin
                    state_next = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (cif.zero) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Intake also pauses before the counter could wrap
    assign ready_next = (state_next == ST_IDLE) && ctrl_reg[wpo_pkg::CTRL_ENABLE] && !cif.near_full;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            o_cmd_ready <= 1'b0;
            o_stalled <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_cmd_ready <= ready_next;
            o_stalled <= (state_next == ST_NP_WAIT) || (state_next == ST_DRAIN);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_wr_valid <= 1'b0;
            o_wr_posted <= 1'b0;
            o_wr_addr <= '0;
            o_wr_data <= '0;
            pend_np_reg <= 1'b0;
            pend_flush_reg <= 1'b0;
        end else if (cmd_take) begin
            o_wr_valid <= dec.wr;
            o_wr_posted <= !dec.np;
            o_wr_addr <= i_cmd_addr;
            o_wr_data <= i_cmd_data;
            pend_np_reg <= dec.np;
            pend_flush_reg <= dec.flush;
        end else if (wr_take) begin
            o_wr_valid <= 1'b0;
        end
    end

    assign cif.inc = wr_take && o_wr_posted;
    assign cif.dec = i_go_valid && i_go_posted;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            posted_cnt_reg <= '0;
            np_cnt_reg <= '0;
        end else if (wr_take && o_wr_posted) begin
            posted_cnt_reg <= posted_cnt_reg + 16'h0001;
        end else if (wr_take) begin
            np_cnt_reg <= np_cnt_reg + 16'h0001;
        end
    end

    // Slave answers one cycle after a request with waitrequest low for exactly one cycle
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= '0;
        end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
            case (i_avs_address)
                wpo_pkg::OFF_CTRL: o_avs_readdata <= {30'h0000_0000, ctrl_reg};
                wpo_pkg::OFF_STATUS: o_avs_readdata <= {16'h0000, cif.count, 6'h00, o_stalled,
                    state_reg != ST_IDLE};
                wpo_pkg::OFF_POSTED_CNT: o_avs_readdata <= {16'h0000, posted_cnt_reg};
                wpo_pkg::OFF_NP_CNT: o_avs_readdata <= {16'h0000, np_cnt_reg};
                default: o_avs_readdata <= '0;
            endcase
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ctrl_reg <= wpo_pkg::CTRL_RESET;
        end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == wpo_pkg::OFF_CTRL
                     && i_avs_byteenable[0]) begin
            ctrl_reg <= i_avs_writedata[1:0];
        end
    end

    chk_posted_no_stall: assert property (@(posedge i_clock) disable iff (i_reset)
        (wr_take && o_wr_posted && !pend_flush_reg && ctrl_reg[wpo_pkg::CTRL_ENABLE] && !cif.near_full)
        |=> o_cmd_ready)
        else $error("posted write stalled intake");
    chk_np_stall: assert property (@(posedge i_clock) disable iff (i_reset)
        (state_reg == ST_NP_WAIT && !np_done) |=> (!o_cmd_ready && o_stalled))
        else $error("intake open before non-posted completion");
    chk_np_retire: assert property (@(posedge i_clock) disable iff (i_reset)
        (state_reg == ST_DRAIN && !cif.zero) |=> !o_cmd_ready)
        else $error("drain left with posted writes outstanding");
    chk_fixed_posted: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_take && !ctrl_reg[wpo_pkg::CTRL_FORCE_NP] && (i_cmd_op == wpo_pkg::OP_REG_TO_MEM
        || i_cmd_op == wpo_pkg::OP_MEM_COPY || i_cmd_op == wpo_pkg::OP_PERF_REPORT))
        |=> (o_wr_valid && o_wr_posted))
        else $error("fixed posted command not posted");
    chk_imm_store: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_take && i_cmd_op == wpo_pkg::OP_IMM_STORE) |=> (o_wr_valid && o_wr_posted ==
        !($past(i_cmd_flags[wpo_pkg::FL_WR_DONE]) || $past(ctrl_reg[wpo_pkg::CTRL_FORCE_NP]))))
        else $error("immediate store posting wrong");
    chk_atomic_sel: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_take && i_cmd_op == wpo_pkg::OP_ATOMIC && i_cmd_flags[wpo_pkg::FL_NP_SEL])
        |=> (o_wr_valid && !o_wr_posted))
        else $error("atomic selection ignored");
    chk_dw_flush: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_take && i_cmd_op == wpo_pkg::OP_DW_FLUSH && i_cmd_flags[wpo_pkg::FL_POST_SYNC])
        |=> (o_wr_valid && !o_wr_posted && state_reg == ST_ISSUE))
        else $error("dword flush write posted");
    chk_pipe_sync: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_take && i_cmd_op == wpo_pkg::OP_PIPE_SYNC && i_cmd_flags[wpo_pkg::FL_POST_SYNC]
        && !ctrl_reg[wpo_pkg::CTRL_FORCE_NP]) |=> (o_wr_posted == !$past(i_cmd_flags[wpo_pkg::FL_STALL])))
        else $error("pipe sync posting wrong");
    chk_flush_drain: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_take && i_cmd_op == wpo_pkg::OP_USER_INT) |=> (state_reg == ST_DRAIN && !o_cmd_ready))
        else $error("user interrupt did not drain");
endmodule // wpo_posting_order
`default_nettype wire

// File: wpo_mem_model.sv
// Behavioural memory subsystem: takes command writes and returns global observation pulses
`timescale 1ns/1ps
`default_nettype none
module wpo_mem_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_wr_valid,
    input wire logic i_wr_posted,
    input wire logic [31:0] i_wr_addr,
    input wire logic i_slow,
    output logic o_wr_ready,
    output logic o_go_valid,
    output logic o_go_posted
);
    int now = 0;
    int np_due = -1;
    int head = 0;
    int tail = 0;
    int nlog = 0;
    int outstanding;
    int due [256];
    logic log_post [256];
    logic [31:0] log_addr [256];
    logic acc;
    logic np_go;
    logic p_go;
    // Slow mode refuses every other cycle and lets posted acknowledges lag far behind
    assign o_wr_ready = !(i_slow && now[0]);
    assign acc = i_wr_valid && o_wr_ready;
    // A non-posted acknowledge overtakes older posted ones, so the engine must rely on its count
    assign np_go = np_due >= 0 && now >= np_due;
    assign p_go = !np_go && head != tail && now >= due[head[7:0]];
    assign outstanding = tail - head + (np_due >= 0 ? 1 : 0);
    always @(posedge i_clock) begin
        if (i_reset) begin
            np_due <= -1;
            head <= 0;
            tail <= 0;
            nlog <= 0;
            o_go_valid <= 1'b0;
            o_go_posted <= 1'b0;
        end else begin
            now <= now + 1;
            o_go_valid <= np_go || p_go;
            // Idle kind line wanders so a stale value is never read as valid
            o_go_posted <= np_go ? 1'b0 : (p_go ? 1'b1 : ~o_go_posted);
            if (np_go) np_due <= -1;
            if (p_go) head <= head + 1;
            if (acc) begin
                log_post[nlog[7:0]] <= i_wr_posted;
                log_addr[nlog[7:0]] <= i_wr_addr;
                nlog <= nlog + 1;
                if (i_wr_posted) begin
                    due[tail[7:0]] <= now + (i_slow ? 20 : 3);
                    tail <= tail + 1;
                end else begin
                    np_due <= now + 1;
                end
            end
        end
    end
endmodule // wpo_mem_model
`default_nettype wire

// File: cmd_write_posting_order_tb_top.sv
// Self-checking bench for the write posting order engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module cmd_write_posting_order_tb_top;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic cv = 1'b0;
    logic slow = 1'b0;
    logic av_r = 1'b0;
    logic av_w = 1'b0;
    logic [3:0] op = 4'h0;
    logic [3:0] av_a = 4'h0;
    logic [4:0] fl = 5'h00;
    logic [31:0] ca = 32'h0;
    logic [31:0] cd = 32'h0;
    logic [31:0] av_d = 32'h0;
    logic [31:0] rd_v;
    logic c_rdy, w_v, w_p, w_r, go_v, go_p, stl, wreq;
    logic [31:0] w_a, w_d, rd;
    int fail_count = 0;
    int check_count = 0;
    int seq = 0;
    int n_p = 0;
    int n_np = 0;
    wpo_posting_order dut (.i_clock(i_clock), .i_reset(i_reset), .i_cmd_valid(cv), .i_cmd_op(op),
        .i_cmd_flags(fl), .i_cmd_addr(ca), .i_cmd_data(cd), .o_cmd_ready(c_rdy), .o_wr_valid(w_v),
        .o_wr_posted(w_p), .o_wr_addr(w_a), .o_wr_data(w_d), .i_wr_ready(w_r), .i_go_valid(go_v),
        .i_go_posted(go_p), .o_stalled(stl), .i_avs_address(av_a), .i_avs_read(av_r), .i_avs_write(av_w),
        .i_avs_writedata(av_d), .i_avs_byteenable(4'hF), .o_avs_readdata(rd), .o_avs_waitrequest(wreq));
    wpo_mem_model mdl (.i_clock(i_clock), .i_reset(i_reset), .i_wr_valid(w_v), .i_wr_posted(w_p),
        .i_wr_addr(w_a), .i_slow(slow), .o_wr_ready(w_r), .o_go_valid(go_v), .o_go_posted(go_p));
    initial begin
        forever #2.5 i_clock = ~i_clock;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
        av_r <= ~wr;
        av_w <= wr;
        av_a <= a;
        av_d <= d;
        @(posedge i_clock);
        // No local limit: only the watchdog ends a hung access
        while (wreq !== 1'b0) begin
            @(posedge i_clock);
        end
        rd_v = rd;
        av_r <= 1'b0;
        av_w <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
        avs(1'b0, a, 32'h0);
        `CHK(nm, e, rd_v)
    endtask
    // Issues one command and waits until intake opens again
    // Kind: 0 flush only, 1 posted, 2 non-posted, 3 no write, 4 posted write then drain
    task automatic run(input logic [3:0] o, input logic [4:0] f, input int kind);
        int n = 0;
        int k0;
        logic st = 1'b0;
        k0 = mdl.nlog;
        seq++;
        cv <= 1'b1;
        op <= o;
        fl <= f;
        ca <= 32'hA000_0000 + seq;
        cd <= ~(32'hA000_0000 + seq);
        do begin
            @(posedge i_clock);
            n++;
        end while (c_rdy !== 1'b1 && n < 300);
        cv <= 1'b0;
        @(posedge i_clock);
        while (c_rdy !== 1'b1 && n < 600) begin
            st = st | stl;
            @(posedge i_clock);
            n++;
        end
        if (n >= 600) fail_count++;
        if (kind == 1 || kind == 4) n_p++;
        if (kind == 2) n_np++;
        `CHK("writes", (kind == 1 || kind == 2 || kind == 4) ? k0 + 1 : k0, mdl.nlog)
        if (kind == 1 || kind == 2 || kind == 4) begin
            `CHK("posted", kind == 1 || kind == 4, mdl.log_post[k0])
            `CHK("addr", 32'hA000_0000 + seq, mdl.log_addr[k0])
            `CHK("data", ~(32'hA000_0000 + seq), w_d)
        end
        if (kind != 3) `CHK("pending", kind == 1, mdl.outstanding != 0)
        if (kind != 3) `CHK("stalled", kind != 1, st)
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        `CHK("ready in reset", 1'b0, c_rdy)
        `CHK("write in reset", 1'b0, w_v)
        `CHK("wait in reset", 1'b1, wreq)
        @(posedge i_clock);
        rchk(wpo_pkg::OFF_CTRL, 32'h1, "ctrl");
        rchk(wpo_pkg::OFF_STATUS, 32'h0, "status");
        rchk(4'h2, 32'h0, "unmapped");
        avs(1'b1, wpo_pkg::OFF_POSTED_CNT, 32'hFFFF);
        rchk(wpo_pkg::OFF_POSTED_CNT, 32'h0, "read only");
        $display("test registers done");
        for (int pass = 0; pass < 2; pass++) begin
            slow <= pass[0];
            run(wpo_pkg::OP_REG_TO_MEM, 5'h03, 1);
            run(wpo_pkg::OP_MEM_COPY, 5'h03, 1);
            run(wpo_pkg::OP_USER_INT, 5'h00, 0);
            run(wpo_pkg::OP_IDX_STORE, 5'h03, 1);
            run(wpo_pkg::OP_HEAD_REPORT, 5'h03, 1);
            run(wpo_pkg::OP_IMM_STORE, 5'h01, 2);
            run(wpo_pkg::OP_TT_UPDATE, 5'h03, 1);
            run(wpo_pkg::OP_PERF_REPORT, 5'h03, 1);
            run(wpo_pkg::OP_DW_FLUSH, 5'h00, 0);
            run(wpo_pkg::OP_IMM_STORE, 5'h00, 1);
            run(wpo_pkg::OP_ATOMIC, 5'h02, 2);
            run(wpo_pkg::OP_ATOMIC, 5'h00, 1);
            run(wpo_pkg::OP_DW_FLUSH, 5'h04, 2);
            run(wpo_pkg::OP_PIPE_SYNC, 5'h04, 1);
            run(wpo_pkg::OP_PIPE_SYNC, 5'h0C, 2);
            run(wpo_pkg::OP_PIPE_SYNC, 5'h04, 1);
            run(wpo_pkg::OP_PIPE_SYNC, 5'h08, 0);
            run(wpo_pkg::OP_ATOMIC, 5'h00, 1);
            run(wpo_pkg::OP_PIPE_SYNC, 5'h10, 0);
            run(wpo_pkg::OP_PIPE_SYNC, 5'h14, 4);
            run(wpo_pkg::OP_ATOMIC, 5'h00, 1);
            run(wpo_pkg::OP_DW_FLUSH_ALT, 5'h00, 0);
            run(wpo_pkg::OP_NOP, 5'h00, 3);
            $display("test command table pass %0d done", pass);
        end
        avs(1'b1, wpo_pkg::OFF_CTRL, 32'h0);
        cv <= 1'b1;
        repeat (6) @(posedge i_clock);
        `CHK("ready disabled", 1'b0, c_rdy)
        cv <= 1'b0;
        avs(1'b1, wpo_pkg::OFF_CTRL, 32'h3);
        run(wpo_pkg::OP_MEM_COPY, 5'h00, 2);
        avs(1'b1, wpo_pkg::OFF_CTRL, 32'h1);
        run(wpo_pkg::OP_MEM_COPY, 5'h00, 1);
        run(wpo_pkg::OP_USER_INT, 5'h00, 0);
        $display("test control done");
        rchk(wpo_pkg::OFF_STATUS, 32'h0, "status idle");
        rchk(wpo_pkg::OFF_POSTED_CNT, n_p, "posted count");
        rchk(wpo_pkg::OFF_NP_CNT, n_np, "non-posted count");
        $display("test counters done");
        finish_test();
    end
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
endmodule // cmd_write_posting_order_tb_top
`default_nettype wire
